/* File: lsd_ctrl_bank.sv */
// APB register bank steering two auxiliary regulators' sleep and off
// Contract
// - second-regulator control at index 28h, third at 29h, eight bits each.
// - sleep field 00 keeps the normal voltage code regardless of pin.
// - sleep field 11 picks sleep code while assigned pin is low.
// - each regulator's sleep pin is first or second, fixed by factory.
// - bit 0 at 0 forces the regulator off over all control pins.
// - bit 0 at 1 leaves on/off to the normal enable logic.
// - the third-regulator register behaves like the second's.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module lsd_ctrl_bank
   import lsd_pkg::*;
#(
   parameter logic [7:0] FACTORY_SECOND = CTRL_RESET_DEFAULT,
   parameter logic [7:0] FACTORY_THIRD = CTRL_RESET_DEFAULT,
   // 0 = first sleep pin, 1 = second sleep pin
   parameter logic PIN_SEL_SECOND = 1'b0,
   parameter logic PIN_SEL_THIRD = 1'b1,
   parameter int CODE_WIDTH = CODE_W
)
(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [DATA_W-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SLEEP_PIN_FIRST,
   input wire logic SLEEP_PIN_SECOND,
   input wire logic REG_TWO_PIN_ENABLE,
   input wire logic REG_THREE_PIN_ENABLE,
   input wire logic [CODE_WIDTH-1:0] REG_TWO_NORMAL_CODE,
   input wire logic [CODE_WIDTH-1:0] REG_TWO_SLEEP_CODE,
   input wire logic [CODE_WIDTH-1:0] REG_THREE_NORMAL_CODE,
   input wire logic [CODE_WIDTH-1:0] REG_THREE_SLEEP_CODE,
   output logic REG_TWO_ON,
   output logic REG_THREE_ON,
   output logic [CODE_WIDTH-1:0] REG_TWO_CODE,
   output logic [CODE_WIDTH-1:0] REG_THREE_CODE,
   output logic REG_TWO_IN_SLEEP,
   output logic REG_THREE_IN_SLEEP
);
   // sleep code in use when field is 11 and the pin is low
   function automatic logic sleep_active(input logic [1:0] fld,
                                         input logic pin);
      sleep_active = (fld == SLP_ON) && !pin;
   endfunction

   function automatic logic [7:0] ctrl_merge(input logic [7:0] cur,
                                             input logic [7:0] wd);
      ctrl_merge = {2'h0, wd[5:0] & RW_MASK};
   endfunction

   lsd_state_type state_ff, nxt_state;
   logic [7:0] second_ctrl_ff, third_ctrl_ff;
   logic [DATA_W-1:0] prdata_ff, nxt_prdata;
   logic pready_ff, pslverr_ff;
   logic two_on_ff, three_on_ff, two_slp_ff, three_slp_ff;
   logic [CODE_WIDTH-1:0] two_code_ff, three_code_ff;

   lsd_sync_if sif();
   assign sif.pin_first = SLEEP_PIN_FIRST;
   assign sif.pin_second = SLEEP_PIN_SECOND;

   lsd_pin_sync u_sync (
      .clk(CLK_SYS),
      .reset(RESET),
      .sif(sif)
   );

   // address decode
   wire hit_second = (PADDR == ADDR_SECOND_CTRL);
   wire hit_third = (PADDR == ADDR_THIRD_CTRL);
   wire hit_status = (PADDR == ADDR_STATUS);
   wire mapped = hit_second | hit_third | hit_status;
   wire access_edge = PSEL & PENABLE & (state_ff == LSD_ACCESS);
   wire wr_take = access_edge & PWRITE & PSTRB[0] & mapped;
   wire wr_second = wr_take & hit_second;
   wire wr_third = wr_take & hit_third;
   // status register is read-only: a write there is refused
   wire bad_access = !mapped | (PWRITE & hit_status);

   // pin routing fixed at build time, like a factory fuse
   wire pin_two = PIN_SEL_SECOND ? sif.sync_second : sif.sync_first;
   wire pin_three = PIN_SEL_THIRD ? sif.sync_second : sif.sync_first;

   wire two_slp = sleep_active(second_ctrl_ff[SLP_HI:SLP_LO], pin_two);
   wire three_slp = sleep_active(third_ctrl_ff[SLP_HI:SLP_LO], pin_three);
   // soft-off bit low wins over any control pin
   wire two_on = second_ctrl_ff[OFF_N_BIT] & REG_TWO_PIN_ENABLE;
   wire three_on = third_ctrl_ff[OFF_N_BIT] & REG_THREE_PIN_ENABLE;
   wire [CODE_WIDTH-1:0] two_code =
      two_slp ? REG_TWO_SLEEP_CODE : REG_TWO_NORMAL_CODE;
   wire [CODE_WIDTH-1:0] three_code =
      three_slp ? REG_THREE_SLEEP_CODE : REG_THREE_NORMAL_CODE;

   wire [7:0] status_byte = {4'h0, three_slp_ff, two_slp_ff,
                             three_on_ff, two_on_ff};

   always_comb begin
      nxt_prdata = '0;
      if (hit_second) begin
         nxt_prdata = {24'h0, second_ctrl_ff};
      end else if (hit_third) begin
         nxt_prdata = {24'h0, third_ctrl_ff};
      end else if (hit_status) begin
         nxt_prdata = {24'h0, status_byte};
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         LSD_IDLE: begin
            if (PSEL && !PENABLE) begin
               nxt_state = LSD_ACCESS;
            end
         end
         LSD_ACCESS: begin
            nxt_state = LSD_IDLE;
         end
      endcase
   end

   // no wait state: setup, then pready on the first access cycle
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state_ff <= LSD_IDLE;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         pready_ff <= PSEL && !PENABLE;
         pslverr_ff <= PSEL && !PENABLE && bad_access;
         if (PSEL && !PENABLE && !PWRITE) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   // factory word loads on reset; reserved 3:1 pattern kept in it
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         second_ctrl_ff <= {2'h0, FACTORY_SECOND[5:0]};
         third_ctrl_ff <= {2'h0, FACTORY_THIRD[5:0]};
      end else begin
         if (wr_second) begin
            second_ctrl_ff <= ctrl_merge(second_ctrl_ff, PWDATA[7:0]);
         end
         if (wr_third) begin
            third_ctrl_ff <= ctrl_merge(third_ctrl_ff, PWDATA[7:0]);
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         two_on_ff <= 1'b0;
         three_on_ff <= 1'b0;
         two_slp_ff <= 1'b0;
         three_slp_ff <= 1'b0;
         two_code_ff <= '0;
         three_code_ff <= '0;
      end else begin
         two_on_ff <= two_on;
         three_on_ff <= three_on;
         two_slp_ff <= two_slp;
         three_slp_ff <= three_slp;
         two_code_ff <= two_code;
         three_code_ff <= three_code;
      end
   end

   assign PRDATA = prdata_ff;
   assign PREADY = pready_ff;
   assign PSLVERR = pslverr_ff;
   assign REG_TWO_ON = two_on_ff;
   assign REG_THREE_ON = three_on_ff;
   assign REG_TWO_CODE = two_code_ff;
   assign REG_THREE_CODE = three_code_ff;
   assign REG_TWO_IN_SLEEP = two_slp_ff;
   assign REG_THREE_IN_SLEEP = three_slp_ff;

   // assertions
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   soft_off_a: assert property (
      !second_ctrl_ff[OFF_N_BIT] |=> !REG_TWO_ON)
      else $error("second regulator on while soft-off low");
   // sampled reset in the antecedent: the release edge starts no attempt
   pin_on_a: assert property (
      !RESET && second_ctrl_ff[OFF_N_BIT] && REG_TWO_PIN_ENABLE
      |=> REG_TWO_ON)
      else $error("second regulator not on with bit and pin set");
   third_off_a: assert property (
      !third_ctrl_ff[OFF_N_BIT] |=> !REG_THREE_ON)
      else $error("third regulator on while soft-off low");
   sleep_field_off_a: assert property (
      !RESET && second_ctrl_ff[SLP_HI:SLP_LO] == SLP_OFF
      |=> REG_TWO_CODE == $past(REG_TWO_NORMAL_CODE))
      else $error("sleep code used with sleep field 00");
   sleep_sel_a: assert property (
      ($stable(second_ctrl_ff) && second_ctrl_ff[SLP_HI:SLP_LO] == SLP_ON
      && (PIN_SEL_SECOND ? !SLEEP_PIN_SECOND : !SLEEP_PIN_FIRST))[*3]
      |=> REG_TWO_IN_SLEEP)
      else $error("sleep not entered after pin low");
   pin_sync_a: assert property (
      $rose(REG_TWO_IN_SLEEP) && $stable(second_ctrl_ff)
      |-> !$past(pin_two))
      else $error("sleep entered without synchronised pin low");
   write_take_a: assert property (
      wr_second |=> second_ctrl_ff == {2'h0, $past(PWDATA[5:0])})
      else $error("second control write not stored");
   top_zero_a: assert property (
      second_ctrl_ff[7:6] == 2'h0 && third_ctrl_ff[7:6] == 2'h0)
      else $error("read-only bits 7:6 not zero");
   ready_once_a: assert property (
      PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("pready not a single pulse after setup");
   third_on_a: assert property (
      !RESET && third_ctrl_ff[OFF_N_BIT] && REG_THREE_PIN_ENABLE
      |=> REG_THREE_ON)
      else $error("third regulator not on with bit and pin set");
   third_normal_a: assert property (
      !RESET && third_ctrl_ff[SLP_HI:SLP_LO] == SLP_OFF
      |=> REG_THREE_CODE == $past(REG_THREE_NORMAL_CODE))
      else $error("third sleep code used with sleep field 00");
   third_sleep_a: assert property (
      ($stable(third_ctrl_ff) && third_ctrl_ff[SLP_HI:SLP_LO] == SLP_ON
      && (PIN_SEL_THIRD ? !SLEEP_PIN_SECOND : !SLEEP_PIN_FIRST))[*3]
      |=> REG_THREE_IN_SLEEP)
      else $error("third sleep not entered after pin low");
   third_write_a: assert property (
      wr_third |=> third_ctrl_ff == {2'h0, $past(PWDATA[5:0])})
      else $error("third control write not stored");
   err_pulse_a: assert property (
      PSEL && !PENABLE && bad_access |=> PREADY && PSLVERR)
      else $error("refused access answered without error");
   // a refused access must leave both control words alone
   err_no_write_a: assert property (
      PREADY && PSLVERR
      |=> $stable(second_ctrl_ff) && $stable(third_ctrl_ff))
      else $error("control word changed by refused access");
   strobe_drop_a: assert property (
      access_edge && PWRITE && !PSTRB[0]
      |=> $stable(second_ctrl_ff) && $stable(third_ctrl_ff))
      else $error("write with lane 0 strobe low was stored");
   rdata_upper_a: assert property (
      PRDATA[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");

   write_cov: cover property (wr_second ##[1:4] wr_third);
   sleep_cov: cover property ($rose(REG_TWO_IN_SLEEP));
   off_cov: cover property ($fell(REG_THREE_ON));
   err_cov: cover property (PSLVERR);
   status_cov: cover property (PREADY && !PWRITE && hit_status);
endmodule // lsd_ctrl_bank

/* File: lsd_pin_sync.sv */
// two-flop synchronisers for both sleep pins
`timescale 1ns/1ps
module lsd_pin_sync
   import lsd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   lsd_sync_if.dst sif
);
   logic [1:0] meta_ff;
   logic [1:0] stable_ff;
   // first stage read only by second stage
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_ff <= 2'h3;
         stable_ff <= 2'h3;
      end else begin
         meta_ff <= {sif.pin_second, sif.pin_first};
         stable_ff <= meta_ff;
      end
   end
   assign sif.sync_first = stable_ff[0];
   assign sif.sync_second = stable_ff[1];
endmodule // lsd_pin_sync

/* File: lsd_pkg.sv */
// package: offsets, field layout, reset values for regulator control bank
package lsd_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;
   localparam int CODE_W = 8;
   // printed offsets are one apart, not four: kept as indices
   localparam logic [7:0] IDX_SECOND_CTRL = 8'h28;
   localparam logic [7:0] IDX_THIRD_CTRL = 8'h29;
   localparam logic [ADDR_W-1:0] ADDR_SECOND_CTRL = 12'h0A0;
   localparam logic [ADDR_W-1:0] ADDR_THIRD_CTRL = 12'h0A4;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h0A8;
   localparam int SLP_HI = 5;
   localparam int SLP_LO = 4;
   localparam int RSV_HI = 3;
   localparam int RSV_LO = 1;
   localparam int OFF_N_BIT = 0;
   localparam logic [5:0] RW_MASK = 6'h3F;
   localparam logic [1:0] SLP_OFF = 2'h0;
   localparam logic [1:0] SLP_ON = 2'h3;
   localparam logic [2:0] RSV_PATTERN = 3'h6;
   localparam logic [7:0] CTRL_RESET_DEFAULT = 8'h0D;
   localparam int SYNC_STAGES = 2;
   typedef enum logic {LSD_IDLE, LSD_ACCESS} lsd_state_type;
endpackage

/* File: lsd_sync_if.sv */
// interface: sleep pins raw in, synchronised levels out
`timescale 1ns/1ps
interface lsd_sync_if;
   logic pin_first;
   logic pin_second;
   logic sync_first;
   logic sync_second;
   modport src (output pin_first, output pin_second,
                input sync_first, input sync_second);
   modport dst (input pin_first, input pin_second,
                output sync_first, output sync_second);
endinterface

/* File: tb_top.sv */
// self-checking bench for the regulator control bank
`timescale 1ns/1ps
module tb_top
   import lsd_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic pin_first = 1'b1;
   logic pin_second = 1'b1;
   logic pin_en = 1'b1;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic two_on, three_on, two_slp, three_slp;
   logic [7:0] two_code, three_code;
   logic [DATA_W-1:0] rd;
   logic err;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   always #25 clk_sys = ~clk_sys;
   lsd_ctrl_bank uut (.CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SLEEP_PIN_FIRST(pin_first), .SLEEP_PIN_SECOND(pin_second),
      .REG_TWO_PIN_ENABLE(pin_en), .REG_THREE_PIN_ENABLE(pin_en),
      .REG_TWO_NORMAL_CODE(8'h11), .REG_TWO_SLEEP_CODE(8'h22),
      .REG_THREE_NORMAL_CODE(8'h33), .REG_THREE_SLEEP_CODE(8'h44),
      .REG_TWO_ON(two_on), .REG_THREE_ON(three_on),
      .REG_TWO_CODE(two_code), .REG_THREE_CODE(three_code),
      .REG_TWO_IN_SLEEP(two_slp), .REG_THREE_IN_SLEEP(three_slp));
   task automatic test_done;
      if (num_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // cut a hang short: whole run needs well under 1000 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         num_errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // pin path and write path both settle within three edges
   task automatic settle;
      repeat (4) @(posedge clk_sys);
   endtask
   function automatic logic [9:0] obs(input int r);
      return r ? {three_on, three_slp, three_code}
               : {two_on, two_slp, two_code};
   endfunction
   task automatic reset_and_map;
      apb(1'b0, ADDR_SECOND_CTRL, 8'h00);
      chk(rd, 32'h0000000D);
      chk({31'h0, err}, 32'h0);
      apb(1'b0, ADDR_THIRD_CTRL, 8'h00);
      chk(rd, 32'h0000000D);
      // bits 7:6 set to prove they read zero; reserved field kept at 110
      apb(1'b1, ADDR_SECOND_CTRL, 8'hFD);
      apb(1'b0, ADDR_SECOND_CTRL, 8'h00);
      chk(rd, 32'h0000003D);
      // lane 0 strobe low: write must be dropped
      pstrb <= 4'hE;
      apb(1'b1, ADDR_SECOND_CTRL, 8'h0C);
      pstrb <= 4'hF;
      apb(1'b0, ADDR_SECOND_CTRL, 8'h00);
      chk(rd, 32'h0000003D);
      apb(1'b0, 12'h0B0, 8'h00);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, ADDR_STATUS, 8'hFF);
      chk({31'h0, err}, 32'h1);
   endtask
   // r = 0 second regulator on first pin, r = 1 third on second pin
   task automatic reg_test(input int r);
      logic [ADDR_W-1:0] a;
      logic [7:0] nrm;
      logic [7:0] slp;
      a = r ? ADDR_THIRD_CTRL : ADDR_SECOND_CTRL;
      nrm = r ? 8'h33 : 8'h11;
      slp = r ? 8'h44 : 8'h22;
      apb(1'b1, a, 8'h3D);
      apb(1'b0, a, 8'h00);
      chk(rd, 32'h0000003D);
      pin_first <= 1'b1;
      pin_second <= 1'b1;
      settle();
      chk({22'h0, obs(r)}, {22'h0, 2'b10, nrm});
      pin_first <= (r != 0);
      pin_second <= (r == 0);
      settle();
      chk({22'h0, obs(r)}, {22'h0, 2'b11, slp});
      // status: other regulator on and not asleep, this one on and asleep
      apb(1'b0, ADDR_STATUS, 8'h00);
      chk(rd, r ? 32'h0000000B : 32'h00000007);
      chk({31'h0, err}, 32'h0);
      pin_first <= (r == 0);
      pin_second <= (r != 0);
      settle();
      chk({22'h0, obs(r)}, {22'h0, 2'b10, nrm});
      pin_first <= (r != 0);
      pin_second <= (r == 0);
      apb(1'b1, a, 8'h0D);
      settle();
      chk({22'h0, obs(r)}, {22'h0, 2'b10, nrm});
      apb(1'b1, a, 8'h0C);
      settle();
      chk(32'(obs(r) >> 9), 32'h0);
      apb(1'b1, a, 8'h0D);
      pin_en <= 1'b0;
      settle();
      chk(32'(obs(r) >> 9), 32'h0);
      pin_en <= 1'b1;
      settle();
      chk(32'(obs(r) >> 9), 32'h1);
      pin_first <= 1'b1;
      pin_second <= 1'b1;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      reset_and_map();
      reg_test(0);
      reg_test(1);
      test_done();
   end
endmodule // tb_top
